/* File: core/tale_alert_bank.sv */
/*
  tale_alert_bank: alert-limit and alert-enable register bank with
  latched flags and the active-low alert line.
  assumes: the serial port front end decodes transactions into one-cycle
  write and read strobes with an 8-bit register address; the measurement
  converter presents each result with a one-cycle valid strobe; the
  charger presents its phase as level inputs.
*/
//
// What this block does
// RULE_01: every register is sixteen bits; all enable and flag bits active high.
// RULE_02: host must not write reserved addresses or unused bits.
// RULE_03: registers unsigned, except alert limits which are signed two's complement.
// RULE_04: signed low and high battery voltage limits, battery-voltage format.
// RULE_05: signed low and high input voltage limits, input-voltage format.
// RULE_06: signed low and high system voltage limits, output-voltage format.
// RULE_07: signed high input current limit, input-current format.
// RULE_08: signed low charge current limit, battery-current format.
// RULE_09: signed high die temperature limit, die-temperature format.
// RULE_10: signed high series resistance limit, resistance format.
// RULE_11: signed high thermistor ratio limit meaning cold battery.
// RULE_12: signed low thermistor ratio limit meaning hot battery.
// RULE_13: limit enable gates both monitoring and alert; flags at limit flag register.
// RULE_14: enable bits 15 valid, 13/12 count, 11..6 voltage low/high pairs.
// RULE_15: bits 5 input current, 4 charge current, 3 die, 2 resistance, 1/0 thermistor.
// RULE_16: phase enable gates phase alerts: bits 10 equalize down to 6 bulk.
// RULE_17: suspended alert enabled raises an alert whenever the charger stops.
// RULE_18: input power loss sets suspended flag and pulls the alert line low.
// RULE_19: host does an alert response read before acting on an alert.
// RULE_20: on alert response read, device answers as source and releases line.
// RULE_21: latched flag stays set until host writes zero to that bit.
// RULE_22: alert line is the OR of every enabled, latched flag; an alert response read releases it until a new enabled event.
`timescale 1ns/10ps
`default_nettype none

module tale_alert_bank (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  // decoded register port
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [tale_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [tale_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [tale_pkg::DATA_W-1:0] reg_rdata_o,
  output logic                             reg_ack_o,
  // measurements, signed, one-cycle valid each
  input  wire logic [tale_pkg::DATA_W-1:0] cell_volts_i,
  input  wire logic                        cell_volts_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] supply_volts_i,
  input  wire logic                        supply_volts_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] load_volts_i,
  input  wire logic                        load_volts_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] supply_amps_i,
  input  wire logic                        supply_amps_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] cell_amps_i,
  input  wire logic                        cell_amps_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] chip_heat_i,
  input  wire logic                        chip_heat_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] pack_resistance_i,
  input  wire logic                        pack_resistance_valid_i,
  input  wire logic [tale_pkg::DATA_W-1:0] pack_ratio_i,
  input  wire logic                        pack_ratio_valid_i,
  // events from blocks outside this bank
  input  wire logic                        meas_valid_event_i,
  input  wire logic                        charge_cnt_low_event_i,
  input  wire logic                        charge_cnt_high_event_i,
  // charger phase levels
  input  wire logic                        phase_equalize_i,
  input  wire logic                        phase_absorb_i,
  input  wire logic                        phase_suspended_i,
  input  wire logic                        phase_precharge_i,
  input  wire logic                        phase_bulk_i,
  // alert response address read completed by the host
  input  wire logic                        alert_resp_i,
  output logic                             alert_resp_claim_o,
  // open-drain alert line
  output logic                             alert_n_o,
  output logic                             alert_oe_o
);

  import tale_pkg::*;

  typedef enum logic [1:0] {
    TALE_LINE_IDLE = 2'b01,
    TALE_LINE_PULL = 2'b10
  } tale_line_t;

  typedef struct packed {
    logic [DATA_W-1:0] limit_en;
    logic [DATA_W-1:0] phase_en;
    logic [DATA_W-1:0] limit_flags;
    logic [DATA_W-1:0] phase_flags;
    logic [4:0]        phase_prev;
    logic [DATA_W-1:0] rdata;
    logic              ack;
    logic              claim;
    logic              answered;
    tale_line_t        line;
  } tale_bank_state_t;

  tale_bank_state_t st_reg;
  tale_bank_state_t st_next;

  logic [NUM_LIMITS-1:0]          lim_wr;
  logic [NUM_LIMITS-1:0]          lim_trip;
  logic [NUM_LIMITS*DATA_W-1:0]   lim_val;
  logic [NUM_LIMITS*DATA_W-1:0]   lim_meas;
  logic [NUM_LIMITS-1:0]          lim_meas_vld;
  logic [DATA_W-1:0]              limit_evt;
  logic [DATA_W-1:0]              phase_evt;
  logic [4:0]                     phase_now;
  logic                           pending;
  logic                           fresh;

  // measurement routed to each limit slot, slot k is address k+1
  assign lim_meas = {pack_ratio_i, pack_ratio_i, pack_resistance_i, chip_heat_i,
                     cell_amps_i, supply_amps_i, load_volts_i, load_volts_i,
                     supply_volts_i, supply_volts_i, cell_volts_i, cell_volts_i};
  assign lim_meas_vld = {pack_ratio_valid_i, pack_ratio_valid_i,
                         pack_resistance_valid_i, chip_heat_valid_i,
                         cell_amps_valid_i, supply_amps_valid_i,
                         load_volts_valid_i, load_volts_valid_i,
                         supply_volts_valid_i, supply_volts_valid_i,
                         cell_volts_valid_i, cell_volts_valid_i};

  // limit write strobes
  always_comb begin
    for (int k = 0; k < NUM_LIMITS; k++) begin
      lim_wr[k] = reg_wr_i && (reg_addr_i == ADDR_W'(k + 1));
    end
  end

  // signed limit registers; slots 0-5 compare below when even and above when odd, slots 6, 8, 9, 10 above, slots 7, 11 below
  genvar g;
  generate
    for (g = 0; g < NUM_LIMITS; g++) begin : g_lim
      localparam tale_cmp_dir_t DIR_G =
        (g == 6 || g == 8 || g == 9 || g == 10) ? TALE_CMP_ABOVE :
        (g == 7 || g == 11) ? TALE_CMP_BELOW :
        ((g % 2) == 1) ? TALE_CMP_ABOVE : TALE_CMP_BELOW;
      tale_limit_cmp #(
        .DIR (DIR_G)
      ) u_cmp (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .wr_i         (lim_wr[g]),
        .wdata_i      (reg_wdata_i),
        .meas_i       (lim_meas[g*DATA_W +: DATA_W]),
        .meas_valid_i (lim_meas_vld[g]),
        .limit_o      (lim_val[g*DATA_W +: DATA_W]),
        .trip_o       (lim_trip[g])
      ); // see RULE_03 see RULE_04 see RULE_05 see RULE_06 see RULE_07
    end
  endgenerate

  // limit events placed at their enable bit positions
  always_comb begin
    limit_evt                         = '0;
    limit_evt[BIT_MEAS_VALID]         = meas_valid_event_i; // see RULE_14
    limit_evt[BIT_CHARGE_CNT_LOW]     = charge_cnt_low_event_i;
    limit_evt[BIT_CHARGE_CNT_HIGH]    = charge_cnt_high_event_i;
    limit_evt[BIT_CELL_VOLTS_UNDER]   = lim_trip[0];
    limit_evt[BIT_CELL_VOLTS_OVER]    = lim_trip[1];
    limit_evt[BIT_SUPPLY_VOLTS_UNDER] = lim_trip[2];
    limit_evt[BIT_SUPPLY_VOLTS_OVER]  = lim_trip[3];
    limit_evt[BIT_LOAD_VOLTS_UNDER]   = lim_trip[4];
    limit_evt[BIT_LOAD_VOLTS_OVER]    = lim_trip[5];
    limit_evt[BIT_SUPPLY_AMPS_OVER]   = lim_trip[6];  // see RULE_15
    limit_evt[BIT_CELL_AMPS_UNDER]    = lim_trip[7];  // see RULE_08
    limit_evt[BIT_CHIP_HEAT_OVER]     = lim_trip[8];  // see RULE_09
    limit_evt[BIT_PACK_RES_OVER]      = lim_trip[9];  // see RULE_10
    limit_evt[BIT_PACK_COLD]          = lim_trip[10]; // see RULE_11
    limit_evt[BIT_PACK_HOT]           = lim_trip[11]; // see RULE_12
  end

  // charger phase entry events, rising edge of each phase level
  assign phase_now = {phase_equalize_i, phase_absorb_i, phase_suspended_i,
                      phase_precharge_i, phase_bulk_i};
  always_comb begin
    phase_evt                    = '0;
    phase_evt[BIT_EQUALIZE:BIT_BULK] = phase_now & ~st_reg.phase_prev; // see RULE_17
  end

  // any enabled latched flag still outstanding
  assign pending = |(st_reg.limit_flags & st_reg.limit_en) ||
                   |(st_reg.phase_flags & st_reg.phase_en); // see RULE_22
  // enabled event latching this cycle, re-arms the line after a response
  assign fresh = |(limit_evt & st_reg.limit_en) || |(phase_evt & st_reg.phase_en);

  // register file, flag latching, line control
  always_comb begin
    st_next            = st_reg;
    st_next.ack        = reg_wr_i || reg_rd_i;
    st_next.claim      = 1'b0;
    st_next.phase_prev = phase_now;
    // unused bits stay zero even if a host writes them
    if (reg_wr_i && reg_addr_i == OFS_LIMIT_ALERT_ENABLE_MASK) begin
      st_next.limit_en = reg_wdata_i & LIMIT_BITS_MASK; // see RULE_01 see RULE_02
    end
    if (reg_wr_i && reg_addr_i == OFS_CHARGE_PHASE_ALERT_ENABLE) begin
      st_next.phase_en = reg_wdata_i & PHASE_BITS_MASK; // see RULE_16
    end
    // writing zero clears a flag, writing one leaves it
    if (reg_wr_i && reg_addr_i == OFS_LIMIT_ALERT_FLAGS) begin
      st_next.limit_flags = st_reg.limit_flags & reg_wdata_i; // see RULE_21
    end
    if (reg_wr_i && reg_addr_i == OFS_CHARGE_PHASE_ALERT_FLAGS) begin
      st_next.phase_flags = st_reg.phase_flags & reg_wdata_i; // see RULE_21
    end
    // new events win over a clear in the same cycle; gated by enable
    st_next.limit_flags = st_next.limit_flags | (limit_evt & st_reg.limit_en); // see RULE_13
    st_next.phase_flags = st_next.phase_flags | (phase_evt & st_reg.phase_en); // see RULE_18
    // read mux
    st_next.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i >= OFS_BATTERY_VOLTAGE_LOW_LIMIT &&
          reg_addr_i <= OFS_THERMISTOR_HOT_LIMIT) begin
        st_next.rdata = lim_val[(reg_addr_i - 8'h01) * DATA_W +: DATA_W];
      end else if (reg_addr_i == OFS_LIMIT_ALERT_ENABLE_MASK) begin
        st_next.rdata = st_reg.limit_en;
      end else if (reg_addr_i == OFS_CHARGE_PHASE_ALERT_ENABLE) begin
        st_next.rdata = st_reg.phase_en;
      end else if (reg_addr_i == OFS_LIMIT_ALERT_FLAGS) begin
        st_next.rdata = st_reg.limit_flags;
      end else if (reg_addr_i == OFS_CHARGE_PHASE_ALERT_FLAGS) begin
        st_next.rdata = st_reg.phase_flags;
      end else begin
        st_next.rdata = '0;
      end
    end
    // answered keeps the line released until a new event or all flags gone
    if (fresh || !pending) begin
      st_next.answered = 1'b0;
    end
    // alert line: pull on a fresh or unanswered alert, release on response read
    case (st_reg.line)
      TALE_LINE_IDLE: begin
        if (fresh || (pending && !st_reg.answered)) begin
          st_next.line = TALE_LINE_PULL; // see RULE_18 see RULE_22
        end
      end
      TALE_LINE_PULL: begin
        if (alert_resp_i) begin
          st_next.line     = TALE_LINE_IDLE; // see RULE_20
          st_next.claim    = 1'b1;
          st_next.answered = 1'b1;
        end else if (!pending) begin
          st_next.line = TALE_LINE_IDLE;
        end
      end
      default: begin
        st_next.line = TALE_LINE_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg.limit_en    <= ENABLE_RESET;
      st_reg.phase_en    <= ENABLE_RESET;
      st_reg.limit_flags <= FLAG_RESET;
      st_reg.phase_flags <= FLAG_RESET;
      st_reg.phase_prev  <= 5'h0_0;
      st_reg.rdata       <= 16'h0000;
      st_reg.ack         <= 1'b0;
      st_reg.claim       <= 1'b0;
      st_reg.answered    <= 1'b0;
      st_reg.line        <= TALE_LINE_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; the line is only ever driven low
  assign reg_rdata_o        = st_reg.rdata;
  assign reg_ack_o          = st_reg.ack;
  assign alert_resp_claim_o = st_reg.claim; // see RULE_20
  assign alert_oe_o         = (st_reg.line == TALE_LINE_PULL);
  assign alert_n_o          = 1'b0;

endmodule

`default_nettype wire

/* File: core/tale_pkg.sv */
/*
  tale_pkg: constants shared by the telemetry alert-limit block.
  assumes: 16-bit register map, one clock domain, synchronous reset.
*/
package tale_pkg;

  // register data width
  localparam int unsigned DATA_W = 16;
  // register address width
  localparam int unsigned ADDR_W = 8;

  // register offsets (register map addresses)
  localparam logic [7:0] OFS_BATTERY_VOLTAGE_LOW_LIMIT    = 8'h01;
  localparam logic [7:0] OFS_BATTERY_VOLTAGE_HIGH_LIMIT   = 8'h02;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_LOW_LIMIT      = 8'h03;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_HIGH_LIMIT     = 8'h04;
  localparam logic [7:0] OFS_SYSTEM_VOLTAGE_LOW_LIMIT     = 8'h05;
  localparam logic [7:0] OFS_SYSTEM_VOLTAGE_HIGH_LIMIT    = 8'h06;
  localparam logic [7:0] OFS_INPUT_CURRENT_HIGH_LIMIT     = 8'h07;
  localparam logic [7:0] OFS_CHARGE_CURRENT_LOW_LIMIT     = 8'h08;
  localparam logic [7:0] OFS_DIE_TEMPERATURE_HIGH_LIMIT   = 8'h09;
  localparam logic [7:0] OFS_SERIES_RESISTANCE_HIGH_LIMIT = 8'h0a;
  localparam logic [7:0] OFS_THERMISTOR_COLD_LIMIT        = 8'h0b;
  localparam logic [7:0] OFS_THERMISTOR_HOT_LIMIT         = 8'h0c;
  localparam logic [7:0] OFS_LIMIT_ALERT_ENABLE_MASK      = 8'h0d;
  localparam logic [7:0] OFS_CHARGE_PHASE_ALERT_ENABLE    = 8'h0e;
  localparam logic [7:0] OFS_LIMIT_ALERT_FLAGS            = 8'h36;
  localparam logic [7:0] OFS_CHARGE_PHASE_ALERT_FLAGS     = 8'h37;

  // number of signed limit registers
  localparam int unsigned NUM_LIMITS = 12;

  // reset values
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET   = 16'h0000;

  // implemented bits of the limit enable / flag register (bit 14 reserved)
  localparam logic [15:0] LIMIT_BITS_MASK = 16'hbfff;
  // implemented bits of the charge-phase enable / flag register (10:6)
  localparam logic [15:0] PHASE_BITS_MASK = 16'h07c0;

  // limit enable / flag bit positions
  localparam int unsigned BIT_MEAS_VALID      = 15;
  localparam int unsigned BIT_CHARGE_CNT_LOW  = 13;
  localparam int unsigned BIT_CHARGE_CNT_HIGH = 12;
  localparam int unsigned BIT_CELL_VOLTS_UNDER   = 11;
  localparam int unsigned BIT_CELL_VOLTS_OVER    = 10;
  localparam int unsigned BIT_SUPPLY_VOLTS_UNDER = 9;
  localparam int unsigned BIT_SUPPLY_VOLTS_OVER  = 8;
  localparam int unsigned BIT_LOAD_VOLTS_UNDER   = 7;
  localparam int unsigned BIT_LOAD_VOLTS_OVER    = 6;
  localparam int unsigned BIT_SUPPLY_AMPS_OVER   = 5;
  localparam int unsigned BIT_CELL_AMPS_UNDER    = 4;
  localparam int unsigned BIT_CHIP_HEAT_OVER     = 3;
  localparam int unsigned BIT_PACK_RES_OVER      = 2;
  localparam int unsigned BIT_PACK_COLD          = 1;
  localparam int unsigned BIT_PACK_HOT           = 0;

  // charge-phase enable / flag bit positions
  localparam int unsigned BIT_EQUALIZE  = 10;
  localparam int unsigned BIT_ABSORB    = 9;
  localparam int unsigned BIT_SUSPENDED = 8;
  localparam int unsigned BIT_PRECHARGE = 7;
  localparam int unsigned BIT_BULK      = 6;

  // limit comparison direction
  typedef enum logic {
    TALE_CMP_BELOW = 1'b0,
    TALE_CMP_ABOVE = 1'b1
  } tale_cmp_dir_t;

endpackage

/* File: core/tale_limit_cmp.sv */
/*
  tale_limit_cmp: one signed limit register with its comparator.
  assumes: measurement arrives as a signed 16-bit word with a valid pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module tale_limit_cmp
  import tale_pkg::*;
#(
  parameter tale_pkg::tale_cmp_dir_t DIR = tale_pkg::TALE_CMP_BELOW
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wr_i,
  input  wire logic [tale_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [tale_pkg::DATA_W-1:0] meas_i,
  input  wire logic                       meas_valid_i,
  output logic      [tale_pkg::DATA_W-1:0] limit_o,
  output logic                            trip_o
);

  typedef struct packed {
    logic [DATA_W-1:0] limit;
  } tale_cmp_state_t;

  tale_cmp_state_t st_reg;
  tale_cmp_state_t st_next;

  // load limit on write
  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      st_next.limit = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg.limit <= LIMIT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // signed compare against a fresh measurement
  always_comb begin
    if (DIR == TALE_CMP_ABOVE) begin
      trip_o = meas_valid_i && ($signed(meas_i) > $signed(st_reg.limit));
    end else begin
      trip_o = meas_valid_i && ($signed(meas_i) < $signed(st_reg.limit));
    end
  end

  assign limit_o = st_reg.limit;

endmodule

`default_nettype wire

/* File: verification/tale_alert_bank_props.sv */
/*
  tale_alert_bank_props: port assertions for the alert bank.
  assumes: bound to tale_alert_bank, one clock, sync active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tale_alert_bank_props
  import tale_pkg::*;
(
  input wire logic                        ref_clk_i,
  input wire logic                        rst_i,
  input wire logic                        reg_wr_i,
  input wire logic                        reg_rd_i,
  input wire logic [tale_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tale_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                        reg_ack_o,
  input wire logic                        alert_resp_i,
  input wire logic                        alert_resp_claim_o,
  input wire logic                        alert_n_o,
  input wire logic                        alert_oe_o
);
  import tale_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // register handshake
  property p_ack; (reg_wr_i || reg_rd_i) |=> reg_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_cause; reg_ack_o |-> $past(reg_wr_i || reg_rd_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  property p_rdata_idle; !reg_ack_o |-> reg_rdata_o == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
  property p_unmapped;
    reg_rd_i && reg_addr_i == 8'h49 |=> reg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved read nonzero");
  // enable masks keep reserved bits clear
  property p_lim_mask;
    reg_rd_i && reg_addr_i == OFS_LIMIT_ALERT_ENABLE_MASK |=> !reg_rdata_o[14];
  endproperty
  a_lim_mask: assert property (p_lim_mask) else $error("bit 14 set");
  property p_phase_mask;
    reg_rd_i && reg_addr_i == OFS_CHARGE_PHASE_ALERT_ENABLE
      |=> (reg_rdata_o & 16'hf83f) == 16'h0000;
  endproperty
  a_phase_mask: assert property (p_phase_mask) else $error("unused phase bits");
  // alert response and claim
  property p_claim; alert_resp_i && alert_oe_o |=> alert_resp_claim_o; endproperty
  a_claim: assert property (p_claim) else $error("no claim");
  property p_claim_pulse; alert_resp_claim_o |=> !alert_resp_claim_o; endproperty
  a_claim_pulse: assert property (p_claim_pulse) else $error("claim too long");
  property p_claim_cause; alert_resp_claim_o |-> $past(alert_resp_i); endproperty
  a_claim_cause: assert property (p_claim_cause) else $error("claim uncaused");
  property p_alert_n; alert_n_o == 1'b0; endproperty
  a_alert_n: assert property (p_alert_n) else $error("alert data high");

  c_claim: cover property (alert_resp_claim_o);
  c_alert: cover property ($rose(alert_oe_o));
  c_mask: cover property (reg_rd_i && reg_addr_i == OFS_LIMIT_ALERT_ENABLE_MASK);
endmodule

bind tale_alert_bank tale_alert_bank_props tale_alert_bank_props_inst (
  .ref_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o, .reg_ack_o,
  .alert_resp_i, .alert_resp_claim_o, .alert_n_o, .alert_oe_o);

`default_nettype wire

/* File: verification/tale_host_model.sv */
/*
  tale_host_model: host that answers a pulled alert line with an
  alert response read after a chosen delay.
  assumes: drives on the falling edge of the bench clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tale_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       arm_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       alert_oe_i,
  output logic            alert_resp_o
);
  int cnt;
  initial alert_resp_o = 1'b0;
  // response read dly_i cycles after the line is pulled
  always @(negedge ref_clk_i) begin
    alert_resp_o <= 1'b0;
    if (rst_i || !arm_i || !alert_oe_i) begin
      cnt = 0;
    end else if (cnt == int'(dly_i)) begin
      alert_resp_o <= 1'b1;
      cnt = 0;
    end else begin
      cnt++;
    end
  end
endmodule

`default_nettype wire

/* File: verification/tale_alert_bank_tb.sv */
/*
  tale_alert_bank_tb: self-checking bench for the alert bank.
  assumes: tale_host_model answers alerts; clock 40 MHz.
*/
`timescale 1ns/10ps
`default_nettype none

module tale_alert_bank_tb;
  import tale_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wr = 0, rd = 0, arm = 0, resp, ack, claim, al_n, oe;
  logic [7:0]  addr = '0;
  logic [15:0] wdata = '0, rdata, q, l;
  logic [15:0] meas [8] = '{default: '0};
  logic [15:0] lim [12];
  logic [7:0]  mv = '0;
  logic [2:0]  ev = '0;
  logic [4:0]  ph = '0;
  logic [3:0]  dly = '0;
  logic [31:0] seed = 32'd44;
  int          err_total = 0, n_tests = 0, cyc = 0, b;

  // 40 MHz clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  tale_alert_bank tale_alert_bank_inst (
    .ref_clk_i, .rst_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .cell_volts_i(meas[0]), .cell_volts_valid_i(mv[0]),
    .supply_volts_i(meas[1]), .supply_volts_valid_i(mv[1]),
    .load_volts_i(meas[2]), .load_volts_valid_i(mv[2]),
    .supply_amps_i(meas[3]), .supply_amps_valid_i(mv[3]),
    .cell_amps_i(meas[4]), .cell_amps_valid_i(mv[4]),
    .chip_heat_i(meas[5]), .chip_heat_valid_i(mv[5]),
    .pack_resistance_i(meas[6]), .pack_resistance_valid_i(mv[6]),
    .pack_ratio_i(meas[7]), .pack_ratio_valid_i(mv[7]),
    .meas_valid_event_i(ev[0]), .charge_cnt_low_event_i(ev[1]),
    .charge_cnt_high_event_i(ev[2]), .phase_equalize_i(ph[4]), .phase_absorb_i(ph[3]),
    .phase_suspended_i(ph[2]), .phase_precharge_i(ph[1]), .phase_bulk_i(ph[0]),
    .alert_resp_i(resp), .alert_resp_claim_o(claim), .alert_n_o(al_n), .alert_oe_o(oe));

  tale_host_model tale_host_model_inst (.ref_clk_i, .rst_i, .arm_i(arm), .dly_i(dly),
    .alert_oe_i(oe), .alert_resp_o(resp));

  // xorshift source
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // measurement feeding limit slot i
  function automatic int midx(int i);
    int t [12] = '{0, 0, 1, 1, 2, 2, 3, 4, 5, 6, 7, 7};
    return t[i];
  endfunction

  // slots that trip below their limit
  function automatic logic is_low(int i);
    return i inside {0, 2, 4, 7, 11};
  endfunction

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one register access, strobe pulsed, answer taken with ack
  task acc(input logic we, input logic [7:0] a, input logic [15:0] d);
    wr = we;
    rd = !we;
    addr = a;
    wdata = d;
    @(negedge ref_clk_i);
    wr = 0;
    rd = 0;
    for (int k = 0; k < 4 && ack !== 1'b1; k++) @(negedge ref_clk_i);
    q = rdata;
    if (ack !== 1'b1) chk("ack", 16'h0000, 16'h0001);
    @(negedge ref_clk_i);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    acc(0, a, 16'h0000);
    chk(nm, q, e);
  endtask

  // one-cycle measurement, then time for the flag to land
  task mpulse(input int m, input logic [15:0] v);
    meas[m] = v;
    mv[m] = 1'b1;
    @(negedge ref_clk_i);
    mv[m] = 1'b0;
    meas[m] = ~v;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task results;
    $display("mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 0;
    @(negedge ref_clk_i);
    for (int a = 1; a <= 14; a++) rdchk("reset", 8'(a), 16'h0000);
    rdchk("flag reset", OFS_LIMIT_ALERT_FLAGS, 16'h0000);
    rdchk("reserved", 8'h49, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      lim[i] = rnd();
      acc(1, 8'(i + 1), lim[i]);
    end
    for (int i = 0; i < 12; i++) rdchk("limit", 8'(i + 1), lim[i]);
    acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'hbfff);
    rdchk("limit enable", OFS_LIMIT_ALERT_ENABLE_MASK, 16'hbfff);
    acc(1, OFS_CHARGE_PHASE_ALERT_ENABLE, 16'h07c0);
    rdchk("phase enable", OFS_CHARGE_PHASE_ALERT_ENABLE, 16'h07c0);
    acc(1, OFS_CHARGE_PHASE_ALERT_ENABLE, 16'h0000);
    // each limit slot: gated, at the limit, one step past
    for (int i = 0; i < 12; i++) begin
      b = 11 - i;
      l = (rnd() >> 1) - 16'h4000;
      acc(1, 8'(i + 1), l);
      acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'h0000);
      mpulse(midx(i), is_low(i) ? l - 16'h0001 : l + 16'h0001);
      rdchk("gated", OFS_LIMIT_ALERT_FLAGS, 16'h0000);
      acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'h0001 << b);
      mpulse(midx(i), l);
      rdchk("at limit", OFS_LIMIT_ALERT_FLAGS, 16'h0000);
      mpulse(midx(i), is_low(i) ? l - 16'h0001 : l + 16'h0001);
      chk("alert", {15'h0000, oe}, 16'h0001);
      rdchk("tripped", OFS_LIMIT_ALERT_FLAGS, 16'h0001 << b);
      acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'h0000);
      chk("masked", {15'h0000, oe}, 16'h0000);
      rdchk("held", OFS_LIMIT_ALERT_FLAGS, 16'h0001 << b);
      acc(1, OFS_LIMIT_ALERT_FLAGS, 16'h0000);
      rdchk("cleared", OFS_LIMIT_ALERT_FLAGS, 16'h0000);
    end
    // outside events and charger phases
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 15 : 14 - k;
      acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'h0001 << b);
      ev[k] = 1'b1;
      @(negedge ref_clk_i);
      ev[k] = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rdchk("event", OFS_LIMIT_ALERT_FLAGS, 16'h0001 << b);
      acc(1, OFS_LIMIT_ALERT_FLAGS, 16'h0000);
      chk("released", {15'h0000, oe}, 16'h0000);
    end
    acc(1, OFS_LIMIT_ALERT_ENABLE_MASK, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      acc(1, OFS_CHARGE_PHASE_ALERT_ENABLE, 16'h0001 << (6 + k));
      ph[k] = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      rdchk("phase", OFS_CHARGE_PHASE_ALERT_FLAGS, 16'h0001 << (6 + k));
      ph[k] = 1'b0;
      acc(1, OFS_CHARGE_PHASE_ALERT_FLAGS, 16'h0000);
    end
    // charger stops, host answers promptly and slowly
    arm = 1;
    acc(1, OFS_CHARGE_PHASE_ALERT_ENABLE, 16'h0100);
    for (int d = 0; d < 2; d++) begin
      dly = d ? 4'h6 : 4'h0;
      ph[2] = 1'b1;
      for (int k = 0; k < 10 && oe !== 1'b1; k++) @(negedge ref_clk_i);
      chk("suspend alert", {15'h0000, oe}, 16'h0001);
      chk("alert level", {15'h0000, al_n}, 16'h0000);
      for (int k = 0; k < 30 && claim !== 1'b1; k++) @(negedge ref_clk_i);
      chk("claim", {15'h0000, claim}, 16'h0001);
      chk("release", {15'h0000, oe}, 16'h0000);
      @(negedge ref_clk_i);
      rdchk("suspend flag", OFS_CHARGE_PHASE_ALERT_FLAGS, 16'h0100);
      chk("stays released", {15'h0000, oe}, 16'h0000);
      ph[2] = 1'b0;
      acc(1, OFS_CHARGE_PHASE_ALERT_FLAGS, 16'h0000);
      rdchk("phase clear", OFS_CHARGE_PHASE_ALERT_FLAGS, 16'h0000);
    end
    results();
  end
endmodule

`default_nettype wire
